/* hw/cfg_decode.sv */
`timescale 1ns/1ns
`include "rx_filter_defs.svh"
module cfg_decode (
    cfg_decode_if.decoder dec
);

    // Codes beyond the top of the range saturate at the largest gain
    function automatic rx_filter_pkg::scale_exp_t scale_exp(
        input logic [4:0] code
    );
        logic [4:0] eff;
        eff = (code > `SCALE_MAX_CODE) ? `SCALE_MAX_CODE : code;
        return $signed({1'b0, eff}) - `SCALE_BIAS;
    endfunction

    always_comb begin
        case (dec.corner_code)
            3'h0:    dec.corner_khz = 9'h021;
            3'h1:    dec.corner_khz = 9'h02E;
            3'h2:    dec.corner_khz = 9'h041;
            3'h3:    dec.corner_khz = 9'h05D;
            3'h4:    dec.corner_khz = 9'h084;
            3'h5:    dec.corner_khz = 9'h0BE;
            3'h6:    dec.corner_khz = 9'h0EF;
            default: dec.corner_khz = 9'h11A;
        endcase
    end

    assign dec.decim_factor = {1'b0, dec.decim_code} + 8'h01;
    assign dec.fsk_exp      = scale_exp(dec.fsk_scale_code);
    assign dec.ask_exp      = scale_exp(dec.ask_scale_code);
    assign dec.matched_len  = {1'b0, dec.matched_code} + 5'h01;
    assign dec.slc_shift    = {1'b0, dec.slc_scale_code} + 3'h1;
    assign dec.slc_bw_bad   = dec.slc_bw_code > `SLC_BW_MAX;

    // Unused codes hold the narrowest legal bandwidth
    always_comb begin
        if (dec.slc_bw_bad) begin
            dec.slc_divisor = 6'h30;
        end else begin
            dec.slc_divisor = {dec.slc_bw_code + 3'h1, 3'h0};
        end
    end

endmodule

/* hw/rx_filter_config.sv */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "rx_filter_defs.svh"
module rx_filter_config (
    input  wire logic                      clock,
    input  wire logic                      reset_n,
    input  wire logic [7:0]                addr,
    input  wire logic [7:0]                wr_data,
    input  wire logic                      wr_en,
    input  wire logic                      rd_en,
    output logic      [7:0]                rd_data,
    input  wire logic [7:0]                signal_level,
    output logic      [2:0]                image_corner_code,
    output logic      [8:0]                image_corner_khz,
    output logic      [6:0]                decimation_minus_one,
    output logic      [7:0]                decimation_factor,
    output logic                           fsk_interp_on,
    output logic      [4:0]                fsk_pre_scale,
    output rx_filter_pkg::scale_exp_t      fsk_scale_exp,
    output logic                           ask_interp_on,
    output logic      [4:0]                ask_pre_scale,
    output rx_filter_pkg::scale_exp_t      ask_scale_exp,
    output logic      [3:0]                matched_len_minus_one,
    output logic      [4:0]                matched_len,
    output logic      [7:0]                resampler_osc_tune,
    output logic      [1:0]                ext_slicer_bw_scale,
    output logic      [2:0]                ext_slicer_scale_shift,
    output logic      [2:0]                ext_slicer_manual_bw,
    output logic      [5:0]                ext_slicer_bw_divisor,
    output logic                           ext_slicer_bw_invalid,
    output logic      [7:0]                signal_threshold_level,
    output logic                           signal_detected
);

    rx_filter_pkg::reg_byte_t predecimation_factor_q;
    rx_filter_pkg::reg_byte_t predecimation_scaling_fsk_q;
    rx_filter_pkg::reg_byte_t predecimation_scaling_ask_q;
    rx_filter_pkg::reg_byte_t matched_filter_control_q;
    rx_filter_pkg::reg_byte_t sample_rate_converter_tune_q;
    rx_filter_pkg::reg_byte_t external_slicer_config_q;
    rx_filter_pkg::reg_byte_t signal_threshold_run_q;
    rx_filter_pkg::reg_byte_t image_filter_corner_select_q;
    rx_filter_pkg::reg_byte_t status_d;
    rx_filter_pkg::reg_byte_t rd_data_d;
    rx_filter_pkg::reg_byte_t rd_data_q;
    rx_filter_pkg::reg_sel_t  sel;

    logic      [8:0]               corner_khz_q;
    logic      [7:0]               decim_factor_q;
    rx_filter_pkg::scale_exp_t     fsk_exp_q;
    rx_filter_pkg::scale_exp_t     ask_exp_q;
    logic      [4:0]               matched_len_q;
    logic      [2:0]               slc_shift_q;
    logic      [5:0]               slc_divisor_q;
    logic                          slc_bw_bad_q;
    logic                          detected_q;

    cfg_decode_if dif ();

    cfg_decode u_decode (
        .dec (dif.decoder)
    );

    always_comb begin
        case (addr)
            `OFS_PREDECIM:  sel = rx_filter_pkg::SEL_PREDECIM;
            `OFS_SCALE_FSK: sel = rx_filter_pkg::SEL_SCALE_FSK;
            `OFS_SCALE_ASK: sel = rx_filter_pkg::SEL_SCALE_ASK;
            `OFS_MATCHED:   sel = rx_filter_pkg::SEL_MATCHED;
            `OFS_RESAMPLER: sel = rx_filter_pkg::SEL_RESAMPLER;
            `OFS_SLICER:    sel = rx_filter_pkg::SEL_SLICER;
            `OFS_THRESHOLD: sel = rx_filter_pkg::SEL_THRESHOLD;
            `OFS_CORNER:    sel = rx_filter_pkg::SEL_CORNER;
            `OFS_STATUS:    sel = rx_filter_pkg::SEL_STATUS;
            default:        sel = rx_filter_pkg::SEL_NONE;
        endcase
    end

    // Masking on write keeps reserved bits at zero in the flops themselves
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            predecimation_factor_q       <= `RST_PREDECIM;
            predecimation_scaling_fsk_q  <= `RST_SCALE_FSK;
            predecimation_scaling_ask_q  <= `RST_SCALE_ASK;
            matched_filter_control_q     <= `RST_MATCHED;
            sample_rate_converter_tune_q <= `RST_RESAMPLER;
            external_slicer_config_q     <= `RST_SLICER;
            signal_threshold_run_q       <= `RST_THRESHOLD;
            image_filter_corner_select_q <= `RST_CORNER;
        end else if (wr_en) begin
            case (sel)
                rx_filter_pkg::SEL_PREDECIM: begin
                    predecimation_factor_q <= wr_data & `MSK_PREDECIM;
                end
                rx_filter_pkg::SEL_SCALE_FSK: begin
                    predecimation_scaling_fsk_q <= wr_data & `MSK_SCALE;
                end
                rx_filter_pkg::SEL_SCALE_ASK: begin
                    predecimation_scaling_ask_q <= wr_data & `MSK_SCALE;
                end
                rx_filter_pkg::SEL_MATCHED: begin
                    matched_filter_control_q <= wr_data & `MSK_MATCHED;
                end
                rx_filter_pkg::SEL_RESAMPLER: begin
                    sample_rate_converter_tune_q <= wr_data;
                end
                rx_filter_pkg::SEL_SLICER: begin
                    // Unused bandwidth codes are stored as written
                    external_slicer_config_q <= wr_data & `MSK_SLICER;
                end
                rx_filter_pkg::SEL_THRESHOLD: begin
                    signal_threshold_run_q <= wr_data;
                end
                rx_filter_pkg::SEL_CORNER: begin
                    image_filter_corner_select_q <= wr_data & `MSK_CORNER;
                end
                default: begin
                end
            endcase
        end
    end

    assign dif.corner_code    = image_filter_corner_select_q[2:0];
    assign dif.decim_code     = predecimation_factor_q[6:0];
    assign dif.fsk_scale_code = predecimation_scaling_fsk_q[4:0];
    assign dif.ask_scale_code = predecimation_scaling_ask_q[4:0];
    assign dif.matched_code   = matched_filter_control_q[3:0];
    assign dif.slc_scale_code =
        external_slicer_config_q[`POS_SLC_SCALE +: 2];
    assign dif.slc_bw_code    = external_slicer_config_q[2:0];

    // Decoded values lag a write by one cycle; fine for static settings
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            corner_khz_q   <= 9'h11A;
            decim_factor_q <= 8'h01;
            fsk_exp_q      <= -`SCALE_BIAS;
            ask_exp_q      <= -`SCALE_BIAS;
            matched_len_q  <= 5'h08;
            slc_shift_q    <= 3'h1;
            slc_divisor_q  <= 6'h18;
            slc_bw_bad_q   <= 1'b0;
        end else begin
            corner_khz_q   <= dif.corner_khz;
            decim_factor_q <= dif.decim_factor;
            fsk_exp_q      <= dif.fsk_exp;
            ask_exp_q      <= dif.ask_exp;
            matched_len_q  <= dif.matched_len;
            slc_shift_q    <= dif.slc_shift;
            slc_divisor_q  <= dif.slc_divisor;
            slc_bw_bad_q   <= dif.slc_bw_bad;
        end
    end

    // Signal level comes from the same clock, so no synchroniser
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            detected_q <= 1'b0;
        end else begin
            detected_q <= signal_level >= signal_threshold_run_q;
        end
    end

    always_comb begin
        status_d = 8'h00;
        status_d[`POS_ST_DET]    = detected_q;
        status_d[`POS_ST_BAD_BW] = slc_bw_bad_q;
    end

    always_comb begin
        case (sel)
            rx_filter_pkg::SEL_PREDECIM:  rd_data_d = predecimation_factor_q;
            rx_filter_pkg::SEL_SCALE_FSK: begin
                rd_data_d = predecimation_scaling_fsk_q;
            end
            rx_filter_pkg::SEL_SCALE_ASK: begin
                rd_data_d = predecimation_scaling_ask_q;
            end
            rx_filter_pkg::SEL_MATCHED:   begin
                rd_data_d = matched_filter_control_q;
            end
            rx_filter_pkg::SEL_RESAMPLER: begin
                rd_data_d = sample_rate_converter_tune_q;
            end
            rx_filter_pkg::SEL_SLICER:    begin
                rd_data_d = external_slicer_config_q;
            end
            rx_filter_pkg::SEL_THRESHOLD: rd_data_d = signal_threshold_run_q;
            rx_filter_pkg::SEL_CORNER:    begin
                rd_data_d = image_filter_corner_select_q;
            end
            rx_filter_pkg::SEL_STATUS:    rd_data_d = status_d;
            default:                      rd_data_d = 8'h00;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rd_data_q <= 8'h00;
        end else if (rd_en) begin
            rd_data_q <= rd_data_d;
        end else begin
            rd_data_q <= 8'h00;
        end
    end

    assign rd_data                = rd_data_q;
    assign image_corner_code      = image_filter_corner_select_q[2:0];
    assign image_corner_khz       = corner_khz_q;
    assign decimation_minus_one   = predecimation_factor_q[6:0];
    assign decimation_factor      = decim_factor_q;
    assign fsk_interp_on          =
        predecimation_scaling_fsk_q[`POS_INTERP];
    assign fsk_pre_scale          = predecimation_scaling_fsk_q[4:0];
    assign fsk_scale_exp          = fsk_exp_q;
    assign ask_interp_on          =
        predecimation_scaling_ask_q[`POS_INTERP];
    assign ask_pre_scale          = predecimation_scaling_ask_q[4:0];
    assign ask_scale_exp          = ask_exp_q;
    assign matched_len_minus_one  = matched_filter_control_q[3:0];
    assign matched_len            = matched_len_q;
    assign resampler_osc_tune     = sample_rate_converter_tune_q;
    assign ext_slicer_bw_scale    =
        external_slicer_config_q[`POS_SLC_SCALE +: 2];
    assign ext_slicer_scale_shift = slc_shift_q;
    assign ext_slicer_manual_bw   = external_slicer_config_q[2:0];
    assign ext_slicer_bw_divisor  = slc_divisor_q;
    assign ext_slicer_bw_invalid  = slc_bw_bad_q;
    assign signal_threshold_level = signal_threshold_run_q;
    assign signal_detected        = detected_q;

endmodule

/* inc/cfg_decode_if.sv */
`timescale 1ns/1ns
interface cfg_decode_if;
    logic [2:0]                corner_code;
    logic [6:0]                decim_code;
    logic [4:0]                fsk_scale_code;
    logic [4:0]                ask_scale_code;
    logic [3:0]                matched_code;
    logic [1:0]                slc_scale_code;
    logic [2:0]                slc_bw_code;
    logic [8:0]                corner_khz;
    logic [7:0]                decim_factor;
    rx_filter_pkg::scale_exp_t fsk_exp;
    rx_filter_pkg::scale_exp_t ask_exp;
    logic [4:0]                matched_len;
    logic [2:0]                slc_shift;
    logic [5:0]                slc_divisor;
    logic                      slc_bw_bad;

    modport owner (
        output corner_code, decim_code, fsk_scale_code, ask_scale_code,
               matched_code, slc_scale_code, slc_bw_code,
        input  corner_khz, decim_factor, fsk_exp, ask_exp, matched_len,
               slc_shift, slc_divisor, slc_bw_bad
    );

    modport decoder (
        input  corner_code, decim_code, fsk_scale_code, ask_scale_code,
               matched_code, slc_scale_code, slc_bw_code,
        output corner_khz, decim_factor, fsk_exp, ask_exp, matched_len,
               slc_shift, slc_divisor, slc_bw_bad
    );
endinterface

/* inc/rx_filter_defs.svh */
`ifndef RX_FILTER_DEFS_SVH
`define RX_FILTER_DEFS_SVH

// Register offsets, 8-bit address space
`define OFS_PREDECIM   8'h39
`define OFS_SCALE_FSK  8'h3A
`define OFS_SCALE_ASK  8'h3B
`define OFS_MATCHED    8'h3C
`define OFS_RESAMPLER  8'h3D
`define OFS_SLICER     8'h3E
`define OFS_THRESHOLD  8'h3F
`define OFS_CORNER     8'h88
`define OFS_STATUS     8'h89

// Writable bit masks
`define MSK_PREDECIM   8'h7F
`define MSK_SCALE      8'h3F
`define MSK_MATCHED    8'h0F
`define MSK_RESAMPLER  8'hFF
`define MSK_SLICER     8'h1F
`define MSK_THRESHOLD  8'hFF
`define MSK_CORNER     8'h07

// Reset values
`define RST_PREDECIM   8'h00
`define RST_SCALE_FSK  8'h00
`define RST_SCALE_ASK  8'h20
`define RST_MATCHED    8'h07
`define RST_RESAMPLER  8'h00
`define RST_SLICER     8'h02
`define RST_THRESHOLD  8'h00
`define RST_CORNER     8'h07

// Field positions
`define POS_INTERP     5
`define POS_SLC_SCALE  3
`define POS_ST_DET     0
`define POS_ST_BAD_BW  1

// Scale code range and bias
`define SCALE_MAX_CODE 5'h17
`define SCALE_BIAS     6'sh0A

// Highest legal manual slicer bandwidth code
`define SLC_BW_MAX     3'h5

`endif

/* inc/rx_filter_pkg.sv */
package rx_filter_pkg;

    typedef logic [7:0]        reg_byte_t;
    typedef logic signed [5:0] scale_exp_t;

    typedef enum logic [8:0] {
        SEL_NONE      = 9'h000,
        SEL_PREDECIM  = 9'h001,
        SEL_SCALE_FSK = 9'h002,
        SEL_SCALE_ASK = 9'h004,
        SEL_MATCHED   = 9'h008,
        SEL_RESAMPLER = 9'h010,
        SEL_SLICER    = 9'h020,
        SEL_THRESHOLD = 9'h040,
        SEL_CORNER    = 9'h080,
        SEL_STATUS    = 9'h100
    } reg_sel_t;

endpackage

/* sim/rx_filter_config_props.sv */
`timescale 1ns/1ns
module rx_filter_config_props (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] signal_level,
    input wire logic [6:0] decimation_minus_one,
    input wire logic [7:0] decimation_factor,
    input wire logic       fsk_interp_on,
    input wire logic [3:0] matched_len_minus_one,
    input wire logic [4:0] matched_len,
    input wire logic [1:0] ext_slicer_bw_scale,
    input wire logic [2:0] ext_slicer_scale_shift,
    input wire logic [2:0] ext_slicer_manual_bw,
    input wire logic [5:0] ext_slicer_bw_divisor,
    input wire logic       ext_slicer_bw_invalid,
    input wire logic [7:0] signal_threshold_level,
    input wire logic       signal_detected
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // Decoded values lag their field by one cycle
    chk_decim_plus_one: assert property (1 |=> decimation_factor ==
        {1'b0, $past(decimation_minus_one)} + 8'h01)
        else $error("decimation factor wrong");
    chk_matched_len: assert property (1 |=> matched_len ==
        {1'b0, $past(matched_len_minus_one)} + 5'h01)
        else $error("matched length wrong");
    chk_slicer_shift: assert property (1 |=> ext_slicer_scale_shift ==
        {1'b0, $past(ext_slicer_bw_scale)} + 3'h1)
        else $error("slicer scale shift wrong");
    chk_slicer_bw_div: assert property (1 |=>
        ext_slicer_bw_invalid == ($past(ext_slicer_manual_bw) > 3'h5) &&
        ext_slicer_bw_divisor == (($past(ext_slicer_manual_bw) > 3'h5) ?
        6'h30 : {$past(ext_slicer_manual_bw), 3'h0} + 6'h08))
        else $error("slicer divisor wrong");
    chk_thr_write: assert property (wr_en && addr == 8'h3F |=>
        signal_threshold_level == $past(wr_data))
        else $error("threshold write lost");
    // The compare is held low on the release edge, so skip that attempt
    chk_detect_cmp: assert property (reset_n |=> signal_detected ==
        ($past(signal_level) >= $past(signal_threshold_level)))
        else $error("detector compare wrong");
    chk_fsk_interp: assert property (wr_en && addr == 8'h3A |=>
        fsk_interp_on == $past(wr_data[5]))
        else $error("fsk interpolation bit wrong");
    chk_unmapped_zero: assert property (rd_en &&
        addr inside {[8'h40:8'h87]} |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    cover property (wr_en && addr == 8'h3E && wr_data[2:0] > 3'h5);
    cover property ($rose(signal_detected));
    cover property (rd_en && addr == 8'h89);
endmodule

bind rx_filter_config rx_filter_config_props rx_filter_config_props_i (.*);

/* sim/rx_filter_config_test.sv */
`timescale 1ns/1ns
module rx_filter_config_test;
    logic       clock, reset_n, wr_en, rd_en, fsk_interp_on, ask_interp_on;
    logic       ext_slicer_bw_invalid, signal_detected;
    logic [7:0] addr, wr_data, rd_data, signal_level, decimation_factor;
    logic [7:0] resampler_osc_tune, signal_threshold_level;
    logic [2:0] image_corner_code, ext_slicer_scale_shift;
    logic [2:0] ext_slicer_manual_bw;
    logic [8:0] image_corner_khz;
    logic [6:0] decimation_minus_one;
    logic [4:0] fsk_pre_scale, ask_pre_scale, matched_len;
    logic [3:0] matched_len_minus_one;
    logic [1:0] ext_slicer_bw_scale;
    logic [5:0] ext_slicer_bw_divisor;
    rx_filter_pkg::scale_exp_t fsk_scale_exp, ask_scale_exp;
    logic [7:0] sh [0:255];
    logic [7:0] amap [0:11] = '{8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E,
        8'h3F, 8'h88, 8'h89, 8'h00, 8'h40, 8'h87};
    int         err_total = 0;
    int         checks_done = 0;

    rx_filter_config rx_filter_config_i (.*);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic logic [8:0] khz(input logic [2:0] c);
        logic [8:0] t [0:7] = '{9'h021, 9'h02E, 9'h041, 9'h05D, 9'h084,
            9'h0BE, 9'h0EF, 9'h11A};
        return t[c];
    endfunction
    // Codes above 17h saturate at the top exponent
    function automatic logic [5:0] sx(input logic [4:0] c);
        return (c > 5'h17) ? 6'h0D : {1'b0, c} - 6'h0A;
    endfunction
    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            8'h39: return 8'h7F;
            8'h3A, 8'h3B: return 8'h3F;
            8'h3C: return 8'h0F;
            8'h3D, 8'h3F: return 8'hFF;
            8'h3E: return 8'h1F;
            8'h88: return 8'h07;
            default: return 8'h00;
        endcase
    endfunction

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        foreach (sh[i]) sh[i] = 8'h00;
        sh[8'h3B] = 8'h20;
        sh[8'h3C] = 8'h07;
        sh[8'h3E] = 8'h02;
        sh[8'h88] = 8'h07;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        sh[a] = (msk(a) == 8'h00) ? sh[a] : (d & msk(a));
    endtask
    // Status is live, so its expectation is built from the shadow copy
    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = (a != 8'h89) ? sh[a] : {6'h00, sh[8'h3E][2:0] > 3'h5,
            signal_level >= sh[8'h3F]};
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, e);
    endtask
    task automatic chk_outs();
        logic [7:0] s;
        s = sh[8'h3E];
        chk(image_corner_code, sh[8'h88]);
        chk(image_corner_khz, khz(sh[8'h88][2:0]));
        chk(decimation_minus_one, sh[8'h39]);
        chk(decimation_factor, sh[8'h39] + 9'h001);
        chk(fsk_interp_on, sh[8'h3A][5]);
        chk(fsk_pre_scale, sh[8'h3A][4:0]);
        chk(fsk_scale_exp[5:0], sx(sh[8'h3A][4:0]));
        chk(ask_interp_on, sh[8'h3B][5]);
        chk(ask_pre_scale, sh[8'h3B][4:0]);
        chk(ask_scale_exp[5:0], sx(sh[8'h3B][4:0]));
        chk(matched_len_minus_one, sh[8'h3C]);
        chk(matched_len, sh[8'h3C] + 9'h001);
        chk(resampler_osc_tune, sh[8'h3D]);
        chk(ext_slicer_bw_scale, s[4:3]);
        chk(ext_slicer_scale_shift, s[4:3] + 9'h001);
        chk(ext_slicer_manual_bw, s[2:0]);
        chk(ext_slicer_bw_invalid, s[2:0] > 3'h5);
        chk(ext_slicer_bw_divisor, (s[2:0] > 3'h5) ? 9'h030 :
            (s[2:0] + 9'h001) * 9'h008);
        chk(signal_threshold_level, sh[8'h3F]);
    endtask

    initial begin
        reset_n = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        signal_level = 8'h00;
        void'($urandom(42018));
        // Second pass resets from all-ones to catch missed reset values
        for (int r = 0; r < 2; r++) begin
            do_reset();
            foreach (amap[j]) rd(amap[j]);
            chk_outs();
            for (int i = 0; i < 32; i++) begin
                foreach (amap[j]) wr(amap[j], {i[2:0], i[4:0]});
                foreach (amap[j]) rd(amap[j]);
                chk_outs();
            end
        end
        for (int n = 0; n < 300; n++) begin
            logic [7:0] a;
            a = amap[$urandom_range(11)];
            @(posedge clock);
            signal_level <= (n % 4 == 0) ? 8'($urandom) :
                sh[8'h3F] + 8'($urandom_range(2)) - 8'h01;
            wr(a, 8'($urandom));
            rd(a);
            chk(signal_detected, signal_level >= sh[8'h3F]);
        end
        chk_outs();
        tally_and_finish();
    end

    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end
endmodule
